// File: hw/pcs_pkg.sv
// constants for the fetch address and return stack block
package pcs_pkg;

   // ========================================
   // widths and sizes
   localparam int ADDR_W      = 21;
   localparam int PTR_W       = 5;
   localparam int DEPTH       = 31;
   localparam int UPPER_W     = 5;
   localparam int APB_AW      = 8;

   // ========================================
   // register byte addresses
   localparam logic [7:0] OFS_LOW_BYTE    = 8'h00;
   localparam logic [7:0] OFS_HIGH_LATCH  = 8'h04;
   localparam logic [7:0] OFS_UPPER_LATCH = 8'h08;
   localparam logic [7:0] OFS_STACK_PTR   = 8'h0c;
   localparam logic [7:0] OFS_TOP_UPPER   = 8'h10;
   localparam logic [7:0] OFS_TOP_HIGH    = 8'h14;
   localparam logic [7:0] OFS_TOP_LOW     = 8'h18;

   // ========================================
   // pointer register fields
   localparam int BIT_FULL      = 7;
   localparam int BIT_OVERFLOW  = 6;
   localparam int BIT_UNDERFLOW = 5;

   // ========================================
   // reset values and fixed addresses
   localparam logic [ADDR_W-1:0] RST_FETCH   = 21'h000000;
   localparam logic [7:0]        RST_LATCH   = 8'h00;
   localparam logic [PTR_W-1:0]  RST_PTR     = 5'h00;
   localparam logic [ADDR_W-1:0] INSN_STEP   = 21'h000002;
   localparam logic [ADDR_W-1:0] VEC_HIGH    = 21'h000008;
   localparam logic [ADDR_W-1:0] VEC_LOW     = 21'h000018;

endpackage

// File: hw/pcs_stack_mem.sv
// flip-flop storage of the return stack, entries 1 to depth
`timescale 1ns/10ps
`default_nettype none
module pcs_stack_mem #(
   parameter int DEPTH  = 31,
   parameter int PTR_W  = 5,
   parameter int DATA_W = 21
) (
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // write port
   input  wire logic              we,
   input  wire logic [PTR_W-1:0]  waddr,
   input  wire logic [DATA_W-1:0] wdata,
   // read port
   input  wire logic [PTR_W-1:0]  raddr,
   output logic      [DATA_W-1:0] rdata
);

   logic [DATA_W-1:0] ent [1:DEPTH];

   // ========================================
   // storage, no entry behind index zero
   for (genvar i = 1; i <= DEPTH; i++) begin : g_ent
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ent[i] <= '0;
         end else if (we && waddr == PTR_W'(i)) begin
            ent[i] <= wdata;
         end
      end
   end

   // ========================================
   // read, index zero reads as zero
   always_comb begin
      rdata = '0;
      for (int k = 1; k <= DEPTH; k++) begin
         if (raddr == PTR_W'(k)) begin
            rdata = ent[k];
         end
      end
   end

endmodule
`default_nettype wire

// File: hw/pcs_fetch_stack.sv
// fetch address counter with return stack and apb registers
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// Operation
// R1 - fetch address is 21 bits in three bytes
// R2 - low byte readable and writable by software
// R3 - high byte only reachable through high latch
// R4 - upper byte only reachable through upper latch
// R5 - low byte write loads both latches inward
// R6 - low byte read copies upper bytes to latches
// R7 - address bit zero always zero
// R8 - sequential step advances address by two
// R9 - calls and jumps load address from instruction
// R10 - up to thirty-one nested calls or interrupts
// R11 - calls and interrupt acknowledge push address
// R12 - all return kinds pop the address
// R13 - calls and returns leave latches alone
// R14 - 31 by 21 storage, 5-bit pointer
// R15 - software reads, writes pointer and top entry
// R16 - push increments pointer then writes entry
// R17 - pop loads address then decrements pointer
// R18 - reset clears pointer, zero holds no entry
// R19 - full, overflow and underflow status shown
// R20 - top registers show entry at pointer
// R21 - software masks interrupts during top access
// R22 - interrupt pushes and loads priority vector
// R23 - full at 31, sticky overflow and underflow
// R24 - pointer write leaves entries untouched
module pcs_fetch_stack #(
   parameter int DEPTH = pcs_pkg::DEPTH,
   parameter int PTR_W = pcs_pkg::PTR_W
) (
   // clock and reset
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   // apb slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [pcs_pkg::APB_AW-1:0]  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   // instruction sequencer
   input  wire logic                        step_op,
   input  wire logic                        jump_op,
   input  wire logic                        call_op,
   input  wire logic                        return_op,
   input  wire logic [pcs_pkg::ADDR_W-1:0]  target_addr,
   input  wire logic                        irq_ack,
   input  wire logic                        irq_high,
   // status
   output logic      [pcs_pkg::ADDR_W-1:0]  fetch_address,
   output logic                             stack_full,
   output logic                             stack_overflow,
   output logic                             stack_underflow
);

   localparam int AW = pcs_pkg::ADDR_W;
   localparam int UW = pcs_pkg::UPPER_W;
   localparam logic [PTR_W-1:0] PTR_TOP = PTR_W'(DEPTH);

   // ========================================
   // elaboration check
   if (DEPTH != (1 << PTR_W) - 1 || PTR_W != pcs_pkg::PTR_W) begin : g_chk
      $error("pcs_fetch_stack: depth must fill the pointer range");
   end

   logic [7:0]       high_latch;
   logic [UW-1:0]    upper_latch;
   logic [PTR_W-1:0] stack_ptr;
   logic [AW-1:0]    top_entry;
   logic             stk_we;
   logic [PTR_W-1:0] stk_waddr;
   logic [AW-1:0]    stk_wdata;
   logic [AW-1:0]    next_fetch;
   logic [PTR_W-1:0] next_ptr;
   logic             ovf_set;
   logic             unf_set;
   logic             do_irq;
   logic             do_call;
   logic             do_ret;
   logic             do_jump;
   logic             seq_busy;
   logic             acc;
   logic             wr_acc;
   logic             rd_acc;
   logic             addr_ok;
   logic [7:0]       rd_byte;

   // ========================================
   // apb decode
   assign acc    = psel && penable && pready;
   assign wr_acc = acc && pwrite && addr_ok;
   assign rd_acc = acc && !pwrite && addr_ok;

   always_comb begin
      addr_ok = 1'b1;
      rd_byte = 8'h00;
      unique case (paddr)
         pcs_pkg::OFS_LOW_BYTE:    rd_byte = fetch_address[7:0];  // R2
         pcs_pkg::OFS_HIGH_LATCH:  rd_byte = high_latch;
         pcs_pkg::OFS_UPPER_LATCH: rd_byte = 8'(upper_latch);
         pcs_pkg::OFS_STACK_PTR:
            rd_byte = {stack_full, stack_overflow, stack_underflow,
                       stack_ptr};  // R19
         pcs_pkg::OFS_TOP_UPPER:   rd_byte = 8'(top_entry[AW-1:16]); // R20
         pcs_pkg::OFS_TOP_HIGH:    rd_byte = top_entry[15:8];
         pcs_pkg::OFS_TOP_LOW:     rd_byte = top_entry[7:0];
         default:                  addr_ok = 1'b0;
      endcase
   end

   // no wait state; data and error are settled in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         if (psel && !penable) begin
            prdata <= {24'h00_0000, rd_byte};
         end
      end
   end

   // ========================================
   // sequencer priority: irq, call, return, jump, step
   assign do_irq   = irq_ack;
   assign do_call  = !irq_ack && call_op;
   assign do_ret   = !irq_ack && !call_op && return_op;
   assign do_jump  = !irq_ack && !call_op && !return_op && jump_op;
   assign seq_busy = irq_ack || call_op || return_op || jump_op;

   // ========================================
   // next address, pointer and stack write
   always_comb begin
      next_fetch = fetch_address;
      next_ptr   = stack_ptr;
      stk_we     = 1'b0;
      stk_waddr  = stack_ptr;
      stk_wdata  = fetch_address;
      ovf_set    = 1'b0;
      unf_set    = 1'b0;
      if (do_irq || do_call) begin
         // push of the already advanced address
         if (stack_ptr == PTR_TOP) begin
            ovf_set = 1'b1;  // R23
         end else begin
            next_ptr  = stack_ptr + 5'h01;  // R16
            stk_we    = 1'b1;  // R11
            stk_waddr = stack_ptr + 5'h01;  // R16
         end
         if (do_irq) begin
            next_fetch = irq_high ? pcs_pkg::VEC_HIGH
                                  : pcs_pkg::VEC_LOW;  // R22
         end else begin
            next_fetch = {target_addr[AW-1:1], 1'b0};  // R9
         end
      end else if (do_ret) begin
         if (stack_ptr == pcs_pkg::RST_PTR) begin
            unf_set    = 1'b1;  // R23
            next_fetch = pcs_pkg::RST_FETCH;
         end else begin
            // software may have left bit zero set in a top entry
            next_fetch = {top_entry[AW-1:1], 1'b0};  // R17 R7
            next_ptr   = stack_ptr - 5'h01;  // R12
         end
      end else if (do_jump) begin
         next_fetch = {target_addr[AW-1:1], 1'b0};  // R9
      end else begin
         if (wr_acc && paddr == pcs_pkg::OFS_LOW_BYTE) begin
            next_fetch = {upper_latch, high_latch,
                          pwdata[7:1], 1'b0};  // R5
         end else if (step_op) begin
            next_fetch = fetch_address + pcs_pkg::INSN_STEP;  // R8
         end
         if (wr_acc && paddr == pcs_pkg::OFS_STACK_PTR) begin
            next_ptr = pwdata[PTR_W-1:0];  // R24
         end
         if (wr_acc && stack_ptr != pcs_pkg::RST_PTR) begin
            stk_we = 1'b1;
            if (paddr == pcs_pkg::OFS_TOP_UPPER) begin
               stk_wdata = {pwdata[UW-1:0], top_entry[15:0]};  // R15
            end else if (paddr == pcs_pkg::OFS_TOP_HIGH) begin
               stk_wdata = {top_entry[AW-1:16], pwdata[7:0],
                            top_entry[7:0]};
            end else if (paddr == pcs_pkg::OFS_TOP_LOW) begin
               stk_wdata = {top_entry[AW-1:8], pwdata[7:0]};
            end else begin
               stk_we = 1'b0;
            end
         end
      end
   end

   // ========================================
   // fetch address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch_address <= pcs_pkg::RST_FETCH;
      end else begin
         fetch_address <= next_fetch;  // R1 R7
      end
   end

   // ========================================
   // latches, untouched by calls and returns
   always_ff @(posedge pclk or negedge presetn) begin  // R13
      if (!presetn) begin
         high_latch  <= pcs_pkg::RST_LATCH;
         upper_latch <= UW'(pcs_pkg::RST_LATCH);
      end else if (rd_acc && paddr == pcs_pkg::OFS_LOW_BYTE) begin
         high_latch  <= fetch_address[15:8];  // R6
         upper_latch <= fetch_address[AW-1:16];  // R6
      end else if (wr_acc && paddr == pcs_pkg::OFS_HIGH_LATCH) begin
         high_latch  <= pwdata[7:0];  // R3
      end else if (wr_acc && paddr == pcs_pkg::OFS_UPPER_LATCH) begin
         upper_latch <= pwdata[UW-1:0];  // R4
      end
   end

   // ========================================
   // pointer and status flags; hardware set beats software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stack_ptr       <= pcs_pkg::RST_PTR;  // R18
         stack_full      <= 1'b0;
         stack_overflow  <= 1'b0;
         stack_underflow <= 1'b0;
      end else begin
         stack_ptr  <= next_ptr;
         stack_full <= (next_ptr == PTR_TOP);  // R23
         if (ovf_set) begin
            stack_overflow <= 1'b1;  // R23
         end else if (wr_acc && !seq_busy &&
                      paddr == pcs_pkg::OFS_STACK_PTR &&
                      !pwdata[pcs_pkg::BIT_OVERFLOW]) begin
            stack_overflow <= 1'b0;
         end
         if (unf_set) begin
            stack_underflow <= 1'b1;  // R23
         end else if (wr_acc && !seq_busy &&
                      paddr == pcs_pkg::OFS_STACK_PTR &&
                      !pwdata[pcs_pkg::BIT_UNDERFLOW]) begin
            stack_underflow <= 1'b0;
         end
      end
   end

   // ========================================
   // stack storage
   pcs_stack_mem #(
      .DEPTH  (DEPTH),
      .PTR_W  (PTR_W),
      .DATA_W (AW)
   ) u_mem (
      .pclk    (pclk),
      .presetn (presetn),
      .we      (stk_we),
      .waddr   (stk_waddr),
      .wdata   (stk_wdata),
      .raddr   (stack_ptr),
      .rdata   (top_entry)  // R14 R10
   );

   // ========================================
   // assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic is_push;
   logic is_pop;
   assign is_push = (do_irq || do_call) && stack_ptr != PTR_TOP;
   assign is_pop  = do_ret && stack_ptr != pcs_pkg::RST_PTR;

   AST_ALIGN: assert property (fetch_address[0] == 1'b0) // R7
      else $error("fetch address misaligned");

   AST_STEP: assert property (step_op && !seq_busy && !wr_acc // R8
      |=> fetch_address == $past(fetch_address) + 21'h000002)
      else $error("step did not add two");

   AST_PUSH: assert property (is_push // R16
      |=> stack_ptr == $past(stack_ptr) + 5'h01
          && top_entry == $past(fetch_address))
      else $error("push pointer or entry wrong");

   AST_POP: assert property (is_pop // R17
      |=> fetch_address == {$past(top_entry[AW-1:1]), 1'b0}
          && stack_ptr == $past(stack_ptr) - 5'h01)
      else $error("pop address or pointer wrong");

   AST_LOW_WRITE: assert property (!seq_busy && wr_acc // R5
      && paddr == pcs_pkg::OFS_LOW_BYTE
      |=> fetch_address[AW-1:8] == {$past(upper_latch),
                                    $past(high_latch)})
      else $error("low write did not load latches");

   AST_LOW_READ: assert property (rd_acc // R6
      && paddr == pcs_pkg::OFS_LOW_BYTE
      |=> high_latch == $past(fetch_address[15:8])
          && upper_latch == $past(fetch_address[AW-1:16]))
      else $error("low read did not fill latches");

   AST_LATCH_KEEP: assert property ((do_call || do_ret) && !acc // R13
      |=> $stable(high_latch) && $stable(upper_latch))
      else $error("call or return moved a latch");

   AST_VECTOR: assert property (do_irq // R22
      |=> fetch_address == ($past(irq_high) ? 21'h000008
                                            : 21'h000018))
      else $error("interrupt vector wrong");

   AST_OVERFLOW: assert property ((do_irq || do_call) // R23
      && stack_ptr == PTR_TOP
      |=> stack_overflow && stack_ptr == PTR_TOP)
      else $error("overflow not flagged");

   AST_UNDERFLOW: assert property (do_ret && stack_ptr == 5'h00 // R23
      |=> stack_underflow && stack_ptr == 5'h00)
      else $error("underflow not flagged");

   AST_PTR_WRITE: assert property (!seq_busy && wr_acc // R24
      && paddr == pcs_pkg::OFS_STACK_PTR
      |-> !stk_we ##1 stack_ptr == $past(pwdata[PTR_W-1:0]))
      else $error("pointer write disturbed stack");

   AST_READY: assert property (psel && !penable // R15
      |=> pready ##1 !pready)
      else $error("apb answer timing wrong");

   COV_NEST: cover property (is_push ##[1:40] stack_full);
   COV_IRQ_RET: cover property (do_irq ##[1:20] is_pop);
   COV_LOW_RW: cover property (rd_acc && paddr == pcs_pkg::OFS_LOW_BYTE
      ##[1:10] wr_acc && paddr == pcs_pkg::OFS_LOW_BYTE);
   COV_UNF: cover property (do_ret && stack_ptr == 5'h00);

endmodule
`default_nettype wire

// File: test/pcs_seq_model.sv
// instruction sequencer model that drives the block's op lines
`timescale 1ns/10ps
`default_nettype none
module pcs_seq_model (
   // clock
   input  wire logic                       pclk,
   // sequencer ops
   output logic                            step_op,
   output logic                            jump_op,
   output logic                            call_op,
   output logic                            return_op,
   output logic                            irq_ack,
   output logic                            irq_high,
   output logic      [pcs_pkg::ADDR_W-1:0] target_addr
);
   initial begin
      {step_op, jump_op, call_op, return_op, irq_ack, irq_high} = '0;
      target_addr = '0;
   end

   // ========================================
   // one op: 0 step, 1 jump, 2 call, 3 return, 4 interrupt
   // interrupts only raised when no top register access runs
   task automatic do_op(input int kind, input logic [20:0] tgt,
                        input logic hi);
      step_op     <= (kind == 0);
      jump_op     <= (kind == 1);
      call_op     <= (kind == 2);
      return_op   <= (kind == 3);
      irq_ack     <= (kind == 4);
      irq_high    <= hi;
      target_addr <= tgt;
      @(posedge pclk);
      {step_op, jump_op, call_op, return_op, irq_ack} <= '0;
      // released lines flip so a stale value cannot look valid
      irq_high    <= ~hi;
      target_addr <= ~tgt;
      @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// File: test/tb_program_counter_return_stack.sv
// self-checking bench for the fetch address and return stack block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_program_counter_return_stack;
   localparam logic [7:0] LOW  = pcs_pkg::OFS_LOW_BYTE;
   localparam logic [7:0] HLAT = pcs_pkg::OFS_HIGH_LATCH;
   localparam logic [7:0] ULAT = pcs_pkg::OFS_UPPER_LATCH;
   localparam logic [7:0] PTR  = pcs_pkg::OFS_STACK_PTR;
   localparam logic [7:0] TOPU = pcs_pkg::OFS_TOP_UPPER;
   localparam logic [7:0] TOPH = pcs_pkg::OFS_TOP_HIGH;
   localparam logic [7:0] TOPL = pcs_pkg::OFS_TOP_LOW;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        step_op, jump_op, call_op, return_op, irq_ack, irq_high;
   logic        stack_full, stack_overflow, stack_underflow, last_err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, v;
   logic [20:0] target_addr, fetch_address;
   int          error_cnt = 0;
   int          n_tests = 0;

   pcs_fetch_stack dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .step_op(step_op), .jump_op(jump_op), .call_op(call_op),
      .return_op(return_op), .target_addr(target_addr),
      .irq_ack(irq_ack), .irq_high(irq_high),
      .fetch_address(fetch_address), .stack_full(stack_full),
      .stack_overflow(stack_overflow), .stack_underflow(stack_underflow));
   pcs_seq_model seq (.pclk(pclk), .step_op(step_op), .jump_op(jump_op),
      .call_op(call_op), .return_op(return_op), .irq_ack(irq_ack),
      .irq_high(irq_high), .target_addr(target_addr));

   // ========================================
   // closing report
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ========================================
   // apb master, entered just after a rising edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [7:0] d, output logic [31:0] rd);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         finish_test();
      end
      rd = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // idle edge so the transfer's effect is visible on return
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d, v);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00, v);
      `CHK(v, {24'h000000, e})
   endtask
   task automatic op(input int k, input logic [20:0] t, input logic h);
      seq.do_op(k, t, h);
   endtask

   // ========================================
   // scenarios
   task automatic t_reset();
      `CHK(fetch_address, 21'h000000)
      rd(PTR, 8'h00);
      rd(TOPL, 8'h00);
      apb(1'b0, 8'h1c, 8'h00, v);
      `CHK({last_err, v}, 33'h100000000)
   endtask
   task automatic t_seq();
      for (int i = 0; i < 3; i++)
         op(0, 21'h000000, 1'b0);
      `CHK(fetch_address, 21'h000006)
      op(1, 21'h012345, 1'b0);
      `CHK(fetch_address, 21'h012344)
      wr(HLAT, 8'hab);
      wr(ULAT, 8'h1c);
      wr(LOW, 8'h57);
      `CHK(fetch_address, 21'h1cab56)
      op(1, 21'h0abcde, 1'b0);
      rd(HLAT, 8'hab);
      rd(LOW, 8'hde);
      rd(HLAT, 8'hbc);
      rd(ULAT, 8'h0a);
   endtask
   task automatic t_stack();
      op(2, 21'h000100, 1'b0);
      `CHK(fetch_address, 21'h000100)
      rd(PTR, 8'h01);
      rd(TOPL, 8'hde);
      rd(TOPH, 8'hbc);
      rd(TOPU, 8'h0a);
      rd(HLAT, 8'hbc);
      op(4, 21'h000000, 1'b1);
      `CHK(fetch_address, 21'h000008)
      op(4, 21'h000000, 1'b0);
      `CHK(fetch_address, 21'h000018)
      rd(PTR, 8'h03);
      rd(TOPL, 8'h08);
      op(3, 21'h000000, 1'b0);
      `CHK(fetch_address, 21'h000008)
      rd(PTR, 8'h02);
      wr(TOPU, 8'h11);
      wr(TOPH, 8'h22);
      wr(TOPL, 8'h33);
      op(3, 21'h000000, 1'b0);
      `CHK(fetch_address, 21'h112232)
      wr(PTR, 8'h00);
      rd(TOPL, 8'h00);
      wr(PTR, 8'h01);
      rd(TOPL, 8'hde);
      op(3, 21'h000000, 1'b0);
      `CHK(fetch_address, 21'h0abcde)
   endtask
   task automatic t_full();
      for (int i = 0; i < 31; i++)
         op(2, 21'(2 * i + 2), 1'b0);
      `CHK(stack_full, 1'b1)
      rd(PTR, 8'h9f);
      op(2, 21'h000040, 1'b0);
      `CHK({stack_overflow, fetch_address}, {1'b1, 21'h000040})
      rd(PTR, 8'hdf);
      op(3, 21'h000000, 1'b0);
      `CHK({stack_full, fetch_address}, {1'b0, 21'h00003c})
      for (int i = 0; i < 30; i++)
         op(3, 21'h000000, 1'b0);
      `CHK(fetch_address, 21'h0abcde)
      op(3, 21'h000000, 1'b0);
      `CHK({stack_underflow, fetch_address}, {1'b1, 21'h000000})
      rd(PTR, 8'h60);
      wr(PTR, 8'h40);
      rd(PTR, 8'h40);
      wr(PTR, 8'h00);
      rd(PTR, 8'h00);
   endtask

   // ========================================
   // clock, reset, sequence and watchdog
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h00000000;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_seq();
      t_stack();
      t_full();
      finish_test();
   end
   initial begin
      repeat (100000) @(posedge pclk);
      error_cnt++;
      finish_test();
   end
endmodule
`default_nettype wire
